// [verilog/exec_pkg.sv]
// package: opcodes, status bit positions, reset values for the exec datapath
package exec_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  // operation select encodings
  localparam logic [2:0] OP_NONE        = 3'h0;
  localparam logic [2:0] OP_ROTATE      = 3'h1;
  localparam logic [2:0] OP_LIT_SUB     = 3'h2;
  localparam logic [2:0] OP_REG_SUB     = 3'h3;
  localparam logic [2:0] OP_REG_SUB_BRW = 3'h4;
  localparam logic [2:0] OP_HALT        = 3'h5;
  // status register bit positions
  localparam int STAT_BORROW = 0;
  localparam int STAT_NIBBLE = 1;
  localparam int STAT_ZERO   = 2;
  localparam int STAT_PD     = 3;
  localparam int STAT_TO     = 4;
  // reset values
  localparam logic [7:0] ACC_RESET    = 8'h00;
  localparam logic       FLAG_RESET   = 1'b0;
  localparam logic       TO_RESET     = 1'b1;
  localparam logic       PD_RESET     = 1'b1;
  localparam logic [7:0] WDT_CLEARED  = 8'h00;
  localparam logic [7:0] PRE_CLEARED  = 8'h00;
  // register map, byte addresses
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_OPERAND = 4'h4;
  localparam logic [3:0] ADDR_ACC     = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
endpackage

// [verilog/rotate_subtract_sleep_exec.sv]
// top: rotate/subtract/halt execution datapath with axi4-lite register port
`timescale 1ns/1ps
module rotate_subtract_sleep_exec (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             file_we,
  output logic [6:0]       file_addr,
  output logic [7:0]       file_wdata,
  output logic [7:0]       watchdog_counter,
  output logic [7:0]       watchdog_prescaler,
  output logic             halted
);
  // execution state
  logic [7:0] accumulator_reg;
  logic       borrow_out_flag;
  logic       nibble_borrow_flag;
  logic       null_result_flag;
  logic       watchdog_expiry_flag;
  logic       power_down_flag;
  // operand register fields written by software
  logic [7:0] operand_file;
  logic [7:0] operand_lit;
  logic [6:0] operand_addr;
  logic       operand_dest;
  // bus capture
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       do_write;
  logic       exec_go;
  logic [2:0] exec_op;

  // a write executes only once both halves are held and no response is
  // pending, so one command can never run twice off one handshake
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  // control write: bits 2:0 opcode only; destination and address come from the operand register
  assign exec_go = clk_en && do_write && aw_addr == exec_pkg::ADDR_CTRL
                   && w_strb[0];
  assign exec_op = w_data[2:0];

  // write address and data are taken independently, in either order;
  // ready pulses for one cycle so a held request is never taken twice
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 4'h0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= exec_pkg::RESP_OKAY;
    end else if (clk_en) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == exec_pkg::ADDR_CTRL ||
                         aw_addr == exec_pkg::ADDR_OPERAND)
                        ? exec_pkg::RESP_OKAY : exec_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // operand register: file value, literal, file address, destination
  always_ff @(posedge core_clk) begin
    if (reset) begin
      operand_file <= 8'h00;
      operand_lit  <= 8'h00;
      operand_addr <= 7'h00;
      operand_dest <= 1'b0;
    end else if (clk_en && do_write && aw_addr == exec_pkg::ADDR_OPERAND) begin
      if (w_strb[0]) operand_file <= w_data[7:0];
      if (w_strb[1]) operand_lit  <= w_data[15:8];
      if (w_strb[2]) operand_addr <= w_data[22:16];
      if (w_strb[3]) operand_dest <= w_data[24];
    end
  end

  // subtract datapath, 9-bit so bit 8 gives the inverted borrow
  logic [7:0] minuend;
  logic       carry_in;
  logic [8:0] diff;
  logic [4:0] nib;
  logic [7:0] rot;
  always_comb begin
    minuend  = (exec_op == exec_pkg::OP_LIT_SUB) ? operand_lit : operand_file;
    // with-borrow form subtracts the inverted flag: carry in = flag
    carry_in = (exec_op == exec_pkg::OP_REG_SUB_BRW) ? borrow_out_flag
                                                     : 1'b1;
    diff = {1'b0, minuend} + {1'b0, ~accumulator_reg}
           + {8'h00, carry_in};
    nib  = {1'b0, minuend[3:0]} + {1'b0, ~accumulator_reg[3:0]}
           + {4'h0, carry_in};
    rot  = {borrow_out_flag, operand_file[7:1]};
  end

  logic       is_sub;
  logic [7:0] result;
  assign is_sub = exec_op == exec_pkg::OP_LIT_SUB ||
                  exec_op == exec_pkg::OP_REG_SUB ||
                  exec_op == exec_pkg::OP_REG_SUB_BRW;
  assign result = (exec_op == exec_pkg::OP_ROTATE) ? rot : diff[7:0];

  // arithmetic flags; halt and rotate leave nibble and zero alone
  always_ff @(posedge core_clk) begin
    if (reset) begin
      borrow_out_flag    <= exec_pkg::FLAG_RESET;
      nibble_borrow_flag <= exec_pkg::FLAG_RESET;
      null_result_flag   <= exec_pkg::FLAG_RESET;
    end else if (exec_go) begin
      if (exec_op == exec_pkg::OP_ROTATE)
        borrow_out_flag <= operand_file[0];
      if (is_sub) begin
        borrow_out_flag    <= diff[8];
        nibble_borrow_flag <= nib[4];
        null_result_flag   <= diff[7:0] == 8'h00;
      end
    end
  end

  // result routing: literal form always to accumulator, others by dest bit
  always_ff @(posedge core_clk) begin
    if (reset) begin
      accumulator_reg <= exec_pkg::ACC_RESET;
      file_we         <= 1'b0;
      file_addr       <= 7'h00;
      file_wdata      <= 8'h00;
    end else if (clk_en) begin
      file_we <= 1'b0;
      if (exec_go) begin
        if (exec_op == exec_pkg::OP_LIT_SUB) begin
          accumulator_reg <= result;
        end else if (exec_op == exec_pkg::OP_ROTATE || is_sub) begin
          if (operand_dest) begin
            file_we    <= 1'b1;
            file_addr  <= operand_addr;
            file_wdata <= result;
          end else begin
            accumulator_reg <= result;
          end
        end
      end
    end
  end

  // halt request decoded once, shared by the flag and watchdog processes
  logic halt_go;
  logic pre_wrap;
  assign halt_go  = exec_go && exec_op == exec_pkg::OP_HALT;
  assign pre_wrap = &watchdog_prescaler;

  // watchdog prescaler: ticks every enabled cycle while the core runs;
  // it stands still while halted, since the oscillator feeding it stops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      watchdog_prescaler <= exec_pkg::PRE_CLEARED;
    end else if (clk_en) begin
      if (halt_go) begin
        watchdog_prescaler <= exec_pkg::PRE_CLEARED;
      end else if (!halted) begin
        watchdog_prescaler <= watchdog_prescaler + 8'h01;
      end
    end
  end

  // watchdog counter: advances on each prescaler wrap; an overflow only
  // wraps here, the time-out reset itself lives outside this block
  always_ff @(posedge core_clk) begin
    if (reset) begin
      watchdog_counter <= exec_pkg::WDT_CLEARED;
    end else if (clk_en) begin
      if (halt_go) begin
        watchdog_counter <= exec_pkg::WDT_CLEARED;
      end else if (!halted && pre_wrap) begin
        watchdog_counter <= watchdog_counter + 8'h01;
      end
    end
  end

  // halt: clear power-down, set time-out and stop the core
  always_ff @(posedge core_clk) begin
    if (reset) begin
      watchdog_expiry_flag <= exec_pkg::TO_RESET;
      power_down_flag      <= exec_pkg::PD_RESET;
      halted               <= 1'b0;
    end else if (clk_en) begin
      if (halt_go) begin
        power_down_flag      <= 1'b0;
        watchdog_expiry_flag <= 1'b1;
        halted               <= 1'b1;
      end else if (exec_go) begin
        // any other command wakes the core; the oscillator model is outside
        halted <= 1'b0;
      end
    end
  end

  // status byte as software sees it; top three bits always read zero
  // so later flags can be added without breaking older readers
  logic [7:0] status_byte;
  assign status_byte = {3'b000, watchdog_expiry_flag, power_down_flag,
                        null_result_flag, nibble_borrow_flag,
                        borrow_out_flag};
  // read channel, one-cycle answer, unmapped reads give slverr;
  // arready waits for rvalid to clear, so only one read is ever open
  always_ff @(posedge core_clk) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= exec_pkg::RESP_OKAY;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= exec_pkg::RESP_OKAY;
        case (s_axi_araddr)
          exec_pkg::ADDR_CTRL:    s_axi_rdata <= {31'h0, halted};
          exec_pkg::ADDR_OPERAND: s_axi_rdata <= {7'h00, operand_dest,
                                    1'b0, operand_addr, operand_lit,
                                    operand_file};
          exec_pkg::ADDR_ACC:     s_axi_rdata <= {24'h0, accumulator_reg};
          exec_pkg::ADDR_STATUS:  s_axi_rdata <= {24'h0, status_byte};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= exec_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // rotate_subtract_sleep_exec

// [verif/exec_chk_props.sv]
// checker: port-level properties of the exec datapath
`timescale 1ns/1ps
module exec_chk (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       file_we,
  input wire logic [7:0] watchdog_counter,
  input wire logic [7:0] watchdog_prescaler,
  input wire logic       halted
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // entering halt must find the watchdog and its prescaler already cleared
  AST_HALT_WDT: assert property ($rose(halted) |->
    watchdog_counter == 8'h00 && watchdog_prescaler == 8'h00)
    else $error("halt left watchdog not cleared");
  AST_HALT_FROZEN: assert property (halted |=>
    $stable(watchdog_prescaler) && $stable(watchdog_counter))
    else $error("watchdog ran while halted");
  AST_HALT_NO_WE: assert property ($rose(halted) |-> !file_we)
    else $error("halt wrote a file register");
  AST_WE_NOT_HALTED: assert property (file_we |-> !halted)
    else $error("file write while halted");
  // a file write only lands with the response of the control write
  AST_WE_RESP: assert property (file_we |-> $rose(s_axi_bvalid))
    else $error("file write outside a response cycle");
  AST_WE_PULSE: assert property (file_we |=> !file_we)
    else $error("file write longer than one cycle");
  AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held past the handshake");
  AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("bvalid kept after bready");
  AST_R_DROP: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("rvalid kept after rready");
endmodule // exec_chk

bind rotate_subtract_sleep_exec exec_chk i_chk (.*);

// [verif/rotate_subtract_sleep_exec_tb.sv]
// testbench: bus-driven checks of the exec datapath
`timescale 1ns/1ps
module rotate_subtract_sleep_exec_tb;
  logic        core_clk = 1'h0, reset = 1'h1, clk_en = 1'h1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, file_we, halted;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [6:0]  file_addr, last_addr = 7'h00;
  logic [7:0]  file_wdata, last_data = 8'h00;
  logic [7:0]  watchdog_counter, watchdog_prescaler;
  int          failures = 0, tests_run = 0;

  rotate_subtract_sleep_exec i_dut (.*);

  always #5 core_clk = ~core_clk;

  // keep the last file write; it lands as the response is taken
  always @(posedge core_clk) if (file_we) begin
    last_addr <= file_addr;
    last_data <= file_wdata;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one write; address and data released as each is taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, r});
  endtask

  // operand word then control word starts one command
  task automatic op(input logic [31:0] operand, input logic [2:0] code);
    wr(exec_pkg::ADDR_OPERAND, operand, exec_pkg::RESP_OKAY);
    wr(exec_pkg::ADDR_CTRL, {29'h0, code}, exec_pkg::RESP_OKAY);
  endtask

  task automatic st(input logic [7:0] acc, input logic [7:0] stat);
    rd(exec_pkg::ADDR_ACC, {24'h0, acc}, exec_pkg::RESP_OKAY);
    rd(exec_pkg::ADDR_STATUS, {24'h0, stat}, exec_pkg::RESP_OKAY);
  endtask

  task automatic complete_run();
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // status reads as expiry, power-down, zero, nibble borrow, borrow
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'h0;
    st(8'h00, 8'h18);
    op(32'h00001000, exec_pkg::OP_LIT_SUB);
    st(8'h10, 8'h1b);
    op(32'h00000500, exec_pkg::OP_LIT_SUB);
    st(8'hf5, 8'h1a);
    op(32'h00000003, exec_pkg::OP_REG_SUB);
    st(8'h0e, 8'h18);
    op(32'h017f0020, exec_pkg::OP_REG_SUB_BRW);
    st(8'h0e, 8'h19);
    chk({17'h0, last_addr, last_data}, 32'h00007f11);
    op(32'h0000000f, exec_pkg::OP_REG_SUB_BRW);
    st(8'h01, 8'h1b);
    op(32'h00000001, exec_pkg::OP_REG_SUB);
    st(8'h00, 8'h1f);
    op(32'h01050081, exec_pkg::OP_ROTATE);
    st(8'h00, 8'h1f);
    chk({17'h0, last_addr, last_data}, 32'h000005c0);
    op(32'h00000002, exec_pkg::OP_ROTATE);
    st(8'h81, 8'h1e);
    op(32'h00000000, exec_pkg::OP_HALT);
    st(8'h81, 8'h16);
    chk({15'h0, halted, watchdog_counter, watchdog_prescaler},
        32'h00010000);
    wr(4'h2, 32'h0, exec_pkg::RESP_SLVERR);
    rd(4'h2, 32'h0, exec_pkg::RESP_SLVERR);
    complete_run();
  end

  // the sequence needs under two hundred cycles; this allows ten times more
  initial begin
    #20000;
    failures++;
    complete_run();
  end
endmodule // rotate_subtract_sleep_exec_tb
